// [rtl/git_defines.svh]
// Offsets, field positions and reset values of the global interrupt and timer block
`ifndef GIT_DEFINES_SVH
`define GIT_DEFINES_SVH

`define GIT_OFF_INTERRUPT   8'h80
`define GIT_OFF_TIMER       8'h84
`define GIT_OFF_ANC_ONE     8'h88
`define GIT_OFF_ANC_TWO     8'h8C
`define GIT_OFF_MULTIPURPOSE_PIN_BLOCK        8'h90

`define GIT_CH0_CODE_LSB    8
`define GIT_CH1_CODE_LSB    11
`define GIT_CODE_W          3
`define GIT_USED_BITS       14

`define GIT_TC_IRQ_EN       0
`define GIT_TC_RUN          1
`define GIT_TC_ONE_SHOT     2
`define GIT_TC_EXT_CLK      3
`define GIT_TC_ROUTE        4
`define GIT_TC_W            5

`define GIT_BYTE_ZERO       8'h00
`define GIT_DIR_RESET       8'hFF
`define GIT_RELOAD_RESET    16'h0000
`define GIT_RATE_W          2

`endif

// [rtl/git_pkg.sv]
// Types shared by the global interrupt and timer block
package git_pkg;

  typedef enum logic [2:0] {
    SRC_NONE     = 3'h0,
    SRC_RX       = 3'h1,
    SRC_RX_TOUT  = 3'h2,
    SRC_TX       = 3'h3,
    SRC_MODEM    = 3'h4,
    SRC_RESERVED = 3'h5,
    SRC_MULTIPURPOSE_PIN_BLOCK     = 3'h6,
    SRC_TIMER    = 3'h7
  } source_code_t;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN  = 2'b01,
    TMR_HALT = 2'b11
  } timer_state_t;

endpackage

// [rtl/timer_link_if.sv]
// Signals between the register logic and the down counter
`timescale 1ns/1ns
interface timer_link_if;
  logic        run;
  logic        one_shot;
  logic        tick;
  logic        restart;
  logic [15:0] reload;
  logic        timeout;

  modport ctrl  (output run, output one_shot, output tick, output restart, output reload, input timeout);
  modport timer (input run, input one_shot, input tick, input restart, input reload, output timeout);
endinterface

// [rtl/source_priority_encoder.sv]
// Picks the most urgent pending source of one channel
`timescale 1ns/1ns
module source_priority_encoder (
  // Pending sources, bit n stands for code n
  input  wire logic [7:1]              pending,
  // Encoded source
  output git_pkg::source_code_t        code
);

  function automatic git_pkg::source_code_t pick(input logic [7:1] p);
    pick = git_pkg::SRC_NONE;
    for (int i = 7; i >= 1; i--) begin
      if (p[i]) begin
        pick = git_pkg::source_code_t'(i[2:0]);
      end
    end
  endfunction

  assign code = pick(pending);

endmodule // source_priority_encoder

// [rtl/countdown_timer.sv]
// Sixteen-bit down counter with re-trigger and single-shot operation
`timescale 1ns/1ns
module countdown_timer (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Control link
  timer_link_if.timer link
);

  git_pkg::timer_state_t state;
  git_pkg::timer_state_t next_state;
  logic [15:0]           count;
  logic [15:0]           next_count;
  logic                  next_timeout;
  wire                   at_end = (count == 16'h0001);
  wire                   armed  = (link.reload != 16'h0000);

  always_comb begin
    next_state   = state;
    next_count   = count;
    next_timeout = 1'b0;
    unique case (state)
      git_pkg::TMR_IDLE: begin
        if (link.run && armed) begin
          next_state = git_pkg::TMR_RUN;
          next_count = link.reload;
        end
      end
      git_pkg::TMR_RUN: begin
        if (!link.run) begin
          next_state = git_pkg::TMR_IDLE;
        end else if (link.tick) begin
          if (at_end || count == 16'h0000) begin
            next_timeout = 1'b1;
            if (link.one_shot) begin
              next_state = git_pkg::TMR_HALT;
              next_count = 16'h0000;
            end else begin
              next_count = link.reload;
            end
          end else begin
            next_count = count - 16'h0001;
          end
        end
      end
      git_pkg::TMR_HALT: begin
        if (link.restart) begin
          next_state = git_pkg::TMR_IDLE;
        end
      end
      default: begin
        next_state = git_pkg::TMR_IDLE;
      end
    endcase
    if (link.restart && state != git_pkg::TMR_HALT) begin
      next_state = git_pkg::TMR_IDLE;
    end
  end

  // Pause keeps the count while idle; leaving idle and each re-trigger timeout reload it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= git_pkg::TMR_IDLE;
      count        <= 16'h0000;
      link.timeout <= 1'b0;
    end else begin
      state        <= next_state;
      count        <= (state == git_pkg::TMR_IDLE && next_state == git_pkg::TMR_IDLE) ? count : next_count;
      link.timeout <= next_timeout;
    end
  end

endmodule // countdown_timer

// [rtl/global_interrupt_timer_block.sv]
// Global interrupt register, general-purpose timer, sampling rate and multipurpose pins
//
// Operation
// - Summary byte bit0 shows channel 0 request, bit1 channel 1; upper bits zero.
// - Summary bit clears only when the channel's sources clear, not on summary read.
// - Channel 0 code in bits 10:8, channel 1 in 13:11, one dword read.
// - Global register bits 14 to 31 always read zero.
// - Codes: 0 none, 1 receive/line error, 2 timeout, 3 transmit/flow, 4 modem.
// - Code 6 pin interrupt and 7 timer timeout only in channel 0.
// - Priority: receive 1, timeout 2, transmit 3, modem 4, pins 6, timer 7.
// - Global register reads zero after reset.
// - Waking after both channels slept raises a special interrupt.
// - Receive-ready clears below trigger level; receive timeout clears when FIFO empty.
// - Line error clears on line status read; modem on modem read; others identification read.
// - Pin interrupt clears on reading the pin level register.
// - Timer is 16-bit down counter; control bit3 selects external clock pin.
// - Control bit0 enables timer interrupt; reading control byte clears it; the pin 0 route ignores bit0.
// - Control bit1 zero stops or pauses, one starts or restarts counting.
// - Control bit2 zero re-triggers continuously, one selects single shot.
// - Control bit4 routes timer interrupt to output pin 0; bits 7:5 read zero.
// - Reload high and low bytes form the 16-bit start value.
// - Reload reads return programmed value; zero after reset keeps timer disabled.
// - Sampling bit per channel: 0 selects 16X, 1 selects 8X.
// - Pin direction bit 1 input (reset), 0 output.
`timescale 1ns/1ns
`include "git_defines.svh"
module global_interrupt_timer_block #(
  parameter logic [7:0] REVISION_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE   = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [3:0]  reg_be,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  // Channel events from the serial cores
  input  wire logic [1:0]  rx_above_trigger,
  input  wire logic [1:0]  rx_timeout_set,
  input  wire logic [1:0]  rx_fifo_empty,
  input  wire logic [1:0]  line_error_set,
  input  wire logic [1:0]  lsr_read,
  input  wire logic [1:0]  modem_delta_set,
  input  wire logic [1:0]  msr_read,
  input  wire logic [1:0]  tx_ready_set,
  input  wire logic [1:0]  flow_event_set,
  input  wire logic [1:0]  isr_read,
  // Sleep and wake
  input  wire logic        both_asleep,
  input  wire logic        wake_event,
  // Pins
  input  wire logic        external_timer_clock_pin,
  input  wire logic [7:0]  multipurpose_pin_block_in,
  output logic [7:0]       multipurpose_pin_block_out,
  output logic [7:0]       multipurpose_pin_block_oe,
  // Configuration and request outputs
  output logic [1:0]       sampling_rate_select,
  output logic             irq_request
);

  timer_link_if link ();

  // Control and configuration storage
  logic [`GIT_TC_W-1:0]   timer_control_byte;
  logic [7:0]             timer_reload_low;
  logic [7:0]             timer_reload_high;
  logic [`GIT_RATE_W-1:0] rate_bits;
  logic [7:0]             multipurpose_pin_block_irq_mask;
  logic [7:0]             multipurpose_pin_level;
  logic [7:0]             multipurpose_pin_block_tristate;
  logic [7:0]             multipurpose_pin_block_invert;
  logic [7:0]             multipurpose_pin_direction;

  // Sticky sources per channel, then device-wide pin, timer and wake flags
  logic [1:0] line_err_flag;
  logic [1:0] rx_tout_flag;
  logic [1:0] tx_flag;
  logic [1:0] modem_flag;
  logic       multipurpose_pin_block_flag;
  logic       timer_flag;
  logic       wake_flag;
  logic       was_asleep;

  // Synchronisers
  logic [7:0] multipurpose_pin_block_meta;
  logic [7:0] multipurpose_pin_block_sync;
  logic [7:0] multipurpose_pin_block_prev;
  logic       tck_meta;
  logic       tck_sync;
  logic       tck_prev;

  git_pkg::source_code_t code0;
  git_pkg::source_code_t code1;

  // Address decode
  wire hit_int   = (reg_addr[7:2] == 6'(`GIT_OFF_INTERRUPT >> 2));
  wire hit_timer = (reg_addr[7:2] == 6'(`GIT_OFF_TIMER >> 2));
  wire hit_anc1  = (reg_addr[7:2] == 6'(`GIT_OFF_ANC_ONE >> 2));
  wire hit_anc2  = (reg_addr[7:2] == 6'(`GIT_OFF_ANC_TWO >> 2));
  wire hit_multipurpose_pin_block  = (reg_addr[7:2] == 6'(`GIT_OFF_MULTIPURPOSE_PIN_BLOCK >> 2));

  function automatic logic lane_wr(input logic hit, input int lane);
    lane_wr = reg_wr && hit && reg_be[lane];
  endfunction

  wire wr_tctl   = lane_wr(hit_timer, 0);
  wire wr_tlow   = lane_wr(hit_timer, 2);
  wire wr_thigh  = lane_wr(hit_timer, 3);
  wire wr_rate   = lane_wr(hit_anc1, 0);
  wire wr_mask   = lane_wr(hit_anc2, 3);
  wire wr_level  = lane_wr(hit_multipurpose_pin_block, 0);
  wire wr_tri    = lane_wr(hit_multipurpose_pin_block, 1);
  wire wr_inv    = lane_wr(hit_multipurpose_pin_block, 2);
  wire wr_dir    = lane_wr(hit_multipurpose_pin_block, 3);
  wire rd_tctl   = reg_rd && hit_timer && reg_be[0];
  wire rd_level  = reg_rd && hit_multipurpose_pin_block && reg_be[0];

  // Summary and encoded sources
  // Code 1 merges the receive level with the sticky line error
  wire [1:0] rx_src = rx_above_trigger | line_err_flag;
  wire [7:1] pend0 = {timer_flag && timer_control_byte[`GIT_TC_IRQ_EN], multipurpose_pin_block_flag, 1'b0,
                      modem_flag[0], tx_flag[0], rx_tout_flag[0], rx_src[0]};
  wire [7:1] pend1 = {3'b000, modem_flag[1], tx_flag[1], rx_tout_flag[1],
                      rx_src[1]};
  wire [1:0] summary = {code1 != git_pkg::SRC_NONE, (code0 != git_pkg::SRC_NONE) | wake_flag};

  source_priority_encoder enc0 (
    .pending (pend0),
    .code    (code0)
  );

  source_priority_encoder enc1 (
    .pending (pend1),
    .code    (code1)
  );

  wire [31:0] int_word = {{(32 - `GIT_USED_BITS){1'b0}}, code1, code0, 6'b000000, summary};
  wire [31:0] tmr_word = {timer_reload_high, timer_reload_low, `GIT_BYTE_ZERO, 3'b000, timer_control_byte};
  wire [31:0] anc1_word = {`GIT_BYTE_ZERO, `GIT_BYTE_ZERO, `GIT_BYTE_ZERO, 6'b000000, rate_bits};
  wire [31:0] anc2_word = {multipurpose_pin_block_irq_mask, `GIT_BYTE_ZERO, DEVICE_CODE, REVISION_CODE};
  wire [7:0]  pin_level = (multipurpose_pin_block_sync & multipurpose_pin_direction) | (multipurpose_pin_level & ~multipurpose_pin_direction);
  wire [31:0] multipurpose_pin_block_word = {multipurpose_pin_direction, multipurpose_pin_block_invert, multipurpose_pin_block_tristate, pin_level};
  wire [31:0] sel_word  = hit_int   ? int_word  :
                          hit_timer ? tmr_word  :
                          hit_anc1  ? anc1_word :
                          hit_anc2  ? anc2_word :
                          hit_multipurpose_pin_block  ? multipurpose_pin_block_word : 32'h0000_0000;
  wire [31:0] lane_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};

  // Pin interrupt is edge sensed after polarity and direction
  wire [7:0] active_in = (multipurpose_pin_block_sync ^ multipurpose_pin_block_invert) & multipurpose_pin_direction;
  wire [7:0] prev_in   = (multipurpose_pin_block_prev ^ multipurpose_pin_block_invert) & multipurpose_pin_direction;
  wire       multipurpose_pin_block_edge = |(active_in & ~prev_in & multipurpose_pin_block_irq_mask);

  // Internal clock counts every cycle; external pin counts on its rising edge
  assign link.tick     = timer_control_byte[`GIT_TC_EXT_CLK] ? (tck_sync & ~tck_prev) : 1'b1;
  assign link.run      = timer_control_byte[`GIT_TC_RUN];
  assign link.one_shot = timer_control_byte[`GIT_TC_ONE_SHOT];
  assign link.reload   = {timer_reload_high, timer_reload_low};
  assign link.restart  = wr_tctl && reg_wdata[`GIT_TC_RUN];

  countdown_timer tmr (
    .clk  (clk),
    .rst  (rst),
    .link (link)
  );

  wire route_timer = timer_control_byte[`GIT_TC_ROUTE] && !multipurpose_pin_direction[0];
  wire [7:0] next_multipurpose_pin_block_out = {multipurpose_pin_level[7:1],
                              route_timer ? timer_flag : multipurpose_pin_level[0]};

  assign irq_request          = |summary;
  assign sampling_rate_select = rate_bits;

  // Timer control and reload bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_control_byte <= '0;
      timer_reload_low   <= `GIT_BYTE_ZERO;
      timer_reload_high  <= `GIT_BYTE_ZERO;
    end else begin
      if (wr_tctl)  timer_control_byte <= reg_wdata[`GIT_TC_W-1:0];
      if (wr_tlow)  timer_reload_low   <= reg_wdata[23:16];
      if (wr_thigh) timer_reload_high  <= reg_wdata[31:24];
    end
  end

  // Sampling rate and pin interrupt mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_bits     <= '0;
      multipurpose_pin_block_irq_mask <= `GIT_BYTE_ZERO;
    end else begin
      if (wr_rate) rate_bits     <= reg_wdata[`GIT_RATE_W-1:0];
      if (wr_mask) multipurpose_pin_block_irq_mask <= reg_wdata[31:24];
    end
  end

  // Pin level, three-state, polarity and direction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multipurpose_pin_level     <= `GIT_BYTE_ZERO;
      multipurpose_pin_block_tristate              <= `GIT_BYTE_ZERO;
      multipurpose_pin_block_invert                <= `GIT_BYTE_ZERO;
      multipurpose_pin_direction <= `GIT_DIR_RESET;
    end else begin
      if (wr_level) multipurpose_pin_level     <= reg_wdata[7:0];
      if (wr_tri)   multipurpose_pin_block_tristate              <= reg_wdata[15:8];
      if (wr_inv)   multipurpose_pin_block_invert                <= reg_wdata[23:16];
      if (wr_dir)   multipurpose_pin_direction <= reg_wdata[31:24];
    end
  end

  // Channel sources; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_err_flag <= 2'b00;
      rx_tout_flag  <= 2'b00;
      tx_flag       <= 2'b00;
      modem_flag    <= 2'b00;
    end else begin
      line_err_flag <= line_error_set | (line_err_flag & ~lsr_read);
      rx_tout_flag  <= rx_timeout_set | (rx_tout_flag & ~rx_fifo_empty);
      tx_flag       <= tx_ready_set | flow_event_set | (tx_flag & ~isr_read);
      modem_flag    <= modem_delta_set | (modem_flag & ~msr_read);
    end
  end

  // Device sources, reported in channel 0 only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multipurpose_pin_block_flag  <= 1'b0;
      timer_flag <= 1'b0;
    end else begin
      multipurpose_pin_block_flag  <= multipurpose_pin_block_edge | (multipurpose_pin_block_flag & ~rd_level);
      timer_flag <= link.timeout | (timer_flag & ~rd_tctl);
    end
  end

  // Wake after both channels slept; shows no source code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      was_asleep <= 1'b0;
      wake_flag  <= 1'b0;
    end else begin
      was_asleep <= both_asleep | (was_asleep & ~wake_event);
      wake_flag  <= (wake_event & was_asleep) | (wake_flag & ~isr_read[0]);
    end
  end

  // Two flip-flops before any logic sees a pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multipurpose_pin_block_meta <= `GIT_BYTE_ZERO;
      multipurpose_pin_block_sync <= `GIT_BYTE_ZERO;
      multipurpose_pin_block_prev <= `GIT_BYTE_ZERO;
    end else begin
      multipurpose_pin_block_meta <= multipurpose_pin_block_in;
      multipurpose_pin_block_sync <= multipurpose_pin_block_meta;
      multipurpose_pin_block_prev <= multipurpose_pin_block_sync;
    end
  end

  // Timer pin is slow against clk, so a plain edge detect is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_meta <= 1'b0;
      tck_sync <= 1'b0;
      tck_prev <= 1'b0;
    end else begin
      tck_meta <= external_timer_clock_pin;
      tck_sync <= tck_meta;
      tck_prev <= tck_sync;
    end
  end

  // Read answer one cycle after the strobe; summary read clears nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= sel_word & lane_mask;
    end
  end

  // Pin drivers lag their registers by one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      multipurpose_pin_block_out <= `GIT_BYTE_ZERO;
      multipurpose_pin_block_oe  <= `GIT_BYTE_ZERO;
    end else begin
      multipurpose_pin_block_out <= next_multipurpose_pin_block_out;
      multipurpose_pin_block_oe  <= ~multipurpose_pin_direction & ~multipurpose_pin_block_tristate;
    end
  end

endmodule // global_interrupt_timer_block

// [testbench/git_chk.sv]
// Port checks for the global interrupt and timer block
`timescale 1ns/1ns
module git_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [3:0]  reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Status and configuration
  input wire logic [1:0]  rx_above_trigger,
  input wire logic [1:0]  sampling_rate_select,
  input wire logic        irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd80 = reg_rd && reg_addr[7:2] == 6'h20;
  wire wr88 = reg_wr && reg_addr[7:2] == 6'h22;
  property p_resv; rd80 |=> reg_rdata[31:14] == 18'h0 && reg_rdata[7:2] == 6'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_ch1; rd80 |=> reg_rdata[13:11] < 3'h6; endproperty
  a_ch1: assert property (p_ch1) else $error("device code in channel 1");
  property p_sum; rd80 && reg_be[0] |=> $past(irq_request) == |reg_rdata[1:0]; endproperty
  a_sum: assert property (p_sum) else $error("summary byte disagrees with request");
  property p_rx0; rd80 && reg_be[1] && rx_above_trigger[0] |=> reg_rdata[10:8] == 3'h1; endproperty
  a_rx0: assert property (p_rx0) else $error("channel 0 receive not most urgent");
  property p_rx1; rd80 && reg_be[1:0] == 2'h3 && rx_above_trigger[1] |=> reg_rdata[13:11] == 3'h1 && reg_rdata[1]; endproperty
  a_rx1: assert property (p_rx1) else $error("channel 1 receive code wrong");
  property p_irq; |rx_above_trigger |-> irq_request; endproperty
  a_irq: assert property (p_irq) else $error("receive ready without request");
  property p_tc; reg_rd && reg_addr[7:2] == 6'h21 |=> reg_rdata[15:5] == 11'h000; endproperty
  a_tc: assert property (p_tc) else $error("timer reserved bits set");
  property p_rate; wr88 && reg_be[0] |=> sampling_rate_select == $past(reg_wdata[1:0]); endproperty
  a_rate: assert property (p_rate) else $error("rate select not written");
  property p_rhold; !wr88 |=> $stable(sampling_rate_select); endproperty
  a_rhold: assert property (p_rhold) else $error("rate select changed alone");
endmodule // git_chk

bind global_interrupt_timer_block git_chk git_chk_i (.clk, .rst, .reg_addr, .reg_rd, .reg_wr, .reg_be, .reg_wdata,
  .reg_rdata, .rx_above_trigger, .sampling_rate_select, .irq_request);

// [testbench/git_host.sv]
// Bus host model issuing register reads and writes
`timescale 1ns/1ns
module git_host (
  // Clock
  input wire logic        clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic [3:0]      reg_be,
  output logic [31:0]     reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_be = 4'h0;
    reg_wdata = 32'h0;
  end
  // Idle lines show inverted values so stale data is never trusted
  task automatic rel();
    reg_addr = ~reg_addr;
    reg_be = ~reg_be;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    rel();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_be = 4'hF;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    rel();
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
  endtask
endmodule // git_host

// [testbench/global_interrupt_timer_block_tb.sv]
// Self-checking bench for the global interrupt and timer block
`timescale 1ns/1ns
module global_interrupt_timer_block_tb;
  logic        clk, rst, reg_rd, reg_wr, reg_rvalid, xclk, both_asleep, wake_event, irq_request, tf, mp, wk;
  logic [7:0]  reg_addr, mi, multipurpose_pin_block_out, multipurpose_pin_block_oe;
  logic [3:0]  reg_be;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  ev [0:9];
  logic [1:0]  sampling_rate_select, le;
  logic [4:2]  pd [0:1];
  int          err_count, n_checks, cyc, r;
  int          seq [11] = '{0, 1, 9, 2, 3, 4, 4, 5, 6, 7, 8};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  git_host git_host_i (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid);
  global_interrupt_timer_block global_interrupt_timer_block_i (.clk, .rst, .reg_addr, .reg_rd, .reg_wr, .reg_be,
    .reg_wdata, .reg_rdata, .reg_rvalid, .rx_above_trigger(ev[4]), .rx_timeout_set(ev[2]), .rx_fifo_empty(ev[6]),
    .line_error_set(ev[3]), .lsr_read(ev[5]), .modem_delta_set(ev[0]), .msr_read(ev[8]), .tx_ready_set(ev[1]),
    .flow_event_set(ev[9]), .isr_read(ev[7]), .both_asleep, .wake_event, .external_timer_clock_pin(xclk),
    .multipurpose_pin_block_in(mi), .multipurpose_pin_block_out, .multipurpose_pin_block_oe, .sampling_rate_select, .irq_request);

  function automatic logic [2:0] code(int c);
    if (ev[4][c] | le[c]) return 3'h1;
    if (pd[c][2]) return 3'h2;
    if (pd[c][3]) return 3'h3;
    if (pd[c][4]) return 3'h4;
    if (c == 0 && mp) return 3'h6;
    if (c == 0 && tf) return 3'h7;
    return 3'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    git_host_i.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic g80();
    rchk(8'h80, {18'h0, code(1), code(0), 6'h00, code(1) != 3'h0, code(0) != 3'h0 || wk});
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge clk);
  endtask
  // Pulse an event, or toggle the receive level, then update the model
  task automatic st(int k, int c);
    @(posedge clk);
    #1 ev[k][c] = ~ev[k][c];
    if (k != 4) begin
      @(posedge clk);
      #1 ev[k][c] = 1'b0;
    end
    case (k)
      0: pd[c][4] = 1'b1;
      1, 9: pd[c][3] = 1'b1;
      2: pd[c][2] = 1'b1;
      3: le[c] = 1'b1;
      5: le[c] = 1'b0;
      6: pd[c][2] = 1'b0;
      7: begin
        pd[c][3] = 1'b0;
        if (c == 0) wk = 1'b0;
      end
      8: pd[c][4] = 1'b0;
      default: ;
    endcase
  endtask
  task automatic tm(input logic [7:0] ctl, input logic v);
    git_host_i.wr(8'h84, 4'hF, {r[15:0], 8'h00, ctl});
    cy(r + 6);
    tf = v;
    g80();
  endtask
  // Reading the control byte also clears the timer flag
  task automatic clr(input logic [7:0] ctl);
    rchk(8'h84, {r[15:0], 8'h00, ctl});
    tf = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    {rst, xclk, both_asleep, wake_event, tf, mp, wk} = 7'h40;
    {mi, le, pd[0], pd[1]} = 16'h0000;
    foreach (ev[i]) ev[i] = 2'h0;
    {err_count, n_checks, cyc} = 0;
    void'($urandom(48804));
    cy(20);
    #1 rst = 1'b0;
    g80();
    rchk(8'h90, 32'hFF000000);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[1:0] = i[1:0];
      git_host_i.wr(8'h88, 4'h1, d);
      chk("rate", {30'h0, d[1:0]}, {30'h0, sampling_rate_select});
      rchk(8'h88, {30'h0, i[1:0]});
    end
    git_host_i.wr(8'h8C, 4'hF, 32'hFFFFFFFF);
    rchk(8'h8C, 32'hFF005AA5);
    git_host_i.wr(8'h8C, 4'h8, 32'h01000000);
    for (int c = 0; c < 2; c++) begin
      foreach (seq[j]) begin
        st(seq[j], c);
        g80();
      end
    end
    @(posedge clk);
    #1 mi = 8'h01;
    cy(4);
    mp = 1'b1;
    g80();
    rchk(8'h90, 32'hFF000001);
    mp = 1'b0;
    g80();
    both_asleep = 1'b1;
    @(posedge clk);
    #1 wake_event = 1'b1;
    @(posedge clk);
    #1 wake_event = 1'b0;
    wk = 1'b1;
    g80();
    st(7, 0);
    g80();
    rchk(8'h84, 32'h0000_0000);
    d = $urandom;
    r = d[31:16];
    git_host_i.wr(8'h84, 4'hC, {r[15:0], 16'hFFFF});
    clr(8'h00);
    r = 3 + ($urandom % 8);
    tm(8'h07, 1'b1);
    clr(8'h07);
    cy(r + 6);
    g80();
    tm(8'h03, 1'b1);
    clr(8'h03);
    cy(r + 6);
    tf = 1'b1;
    g80();
    git_host_i.wr(8'h84, 4'h1, 32'h01);
    clr(8'h01);
    cy(r + 6);
    g80();
    tm(8'h06, 1'b0);
    clr(8'h06);
    git_host_i.wr(8'h90, 4'h8, 32'hFE000000);
    tm(8'h16, 1'b0);
    chk("pin out", 32'h3, {30'h0, multipurpose_pin_block_oe[0], multipurpose_pin_block_out[0]});
    clr(8'h16);
    cy(2);
    chk("pin out", 32'h2, {30'h0, multipurpose_pin_block_oe[0], multipurpose_pin_block_out[0]});
    git_host_i.wr(8'h90, 4'h8, 32'hFF000000);
    tm(8'h0F, 1'b0);
    repeat (r + 2) begin
      cy(2);
      #1 xclk = 1'b1;
      cy(2);
      #1 xclk = 1'b0;
    end
    cy(4);
    tf = 1'b1;
    g80();
    clr(8'h0F);
    @(posedge clk);
    #1 rst = 1'b1;
    cy(2);
    #1 rst = 1'b0;
    chk("rate", 32'h0, {30'h0, sampling_rate_select});
    g80();
    rchk(8'h90, 32'hFF000001);
    print_verdict();
  end
endmodule // global_interrupt_timer_block_tb
